// ==== rtl/fpc_pkg.sv ====
// Constants, field layouts and types of the flash program controller
package fpc_pkg;
	// Register byte offsets on the APB side
	localparam logic [7:0] FPC_MODE_OFS = 8'h60;
	localparam logic [7:0] FPC_CMD_OFS  = 8'h64;
	localparam logic [7:0] FPC_STAT_OFS = 8'h68;
	// Mode register fields
	localparam int FPC_EOP_BIT   = 0;
	localparam int FPC_EOL_BIT   = 1;
	localparam int FPC_LOCK_ERROR_FLAG_BIT = 2;
	localparam int FPC_PROGRAM_ERROR_FLAG_BIT = 3;
	localparam int FPC_SKIP_ERASE_BEFORE_WRITE_BIT  = 7;
	localparam int FPC_FWS_LSB   = 8;
	localparam int FPC_MICROSECOND_CYCLE_COUNT_LSB  = 16;
	localparam logic [31:0] FPC_MODE_RESET = 32'h0000_0000;
	// Command register fields
	localparam int FPC_FLASH_COMMAND_CODE_LSB  = 0;
	localparam int FPC_PAGE_NUMBER_LSB = 8;
	localparam int FPC_PAGE_NUMBER_W   = 10;
	localparam int FPC_KEY_LSB   = 24;
	localparam logic [7:0] FPC_KEY = 8'h5A;
	// Status register lock bits start here
	localparam int FPC_LOCKS_LSB = 16;
	// Command codes
	localparam logic [3:0] FPC_CMD_NONE = 4'h0;
	localparam logic [3:0] FPC_CMD_WP   = 4'h1;
	localparam logic [3:0] FPC_CMD_SLB  = 4'h2;
	localparam logic [3:0] FPC_CMD_WPL  = 4'h3;
	localparam logic [3:0] FPC_CMD_CLB  = 4'h4;
	localparam logic [3:0] FPC_CMD_EA   = 4'h8;
	// Access timing in clock cycles
	localparam logic [1:0] FPC_FWS_MAX   = 2'h3;
	localparam logic [2:0] FPC_WR_CAP    = 3'h4;
	localparam logic [2:0] FPC_ONE_CYCLE = 3'h1;
	// Sequencer states
	typedef enum logic [2:0] {
		FPC_IDLE  = 3'b000,
		FPC_ERASE = 3'b001,
		FPC_PROG  = 3'b010,
		FPC_LOCK  = 3'b011,
		FPC_WIPE  = 3'b100
	} fpc_state_t;
endpackage : fpc_pkg

// ==== rtl/fpc_flash_program_controller.sv ====
// Embedded flash controller: read timing, write latch, command sequencer
//
// Function
// - Two 32-bit code buffers; next word prefetched with every code read
// - Wait-state setting 0 to 3; zero gives single-cycle reads
// - Setting one: first sequential code read slow, rest single cycle
// - Setting two/three: each sequential code read takes wait-state count cycles, a repeated word one cycle
// - Flash contents repeat across the whole reserved address region
// - Writes fill a page-sized latch indexed by low address bits
// - Latch writes take one wait state more, except at setting three
// - Decode write page, set lock, write-and-lock, clear lock, erase all
// - Commands accepted only with correct key in top byte
// - Bad key or code sets program error; status read clears it
// - Write or erase into locked region does nothing, sets lock error
// - Write page erases first unless skip-erase set, then programs latch
// - Program or erase-all end sets end-of-program flag, may interrupt
// - Status read clears end-of-program flag and its interrupt
// - Skip-erase set programs page without erasing it
// - Clear lock makes status bit 0; set lock makes it 1
// - Lock state of each region shown in status upper bits
// - Lock end sets end-of-lock flag; no flash access meanwhile
// - Write-and-lock programs page then locks its region
// - Erase all refused with lock error when any region locked
// - Key value 0x5A; any other starts nothing
`timescale 1ns/1ps
module fpc_flash_program_controller #(
	parameter int         PAGES      = 1024,
	parameter int         PAGE_WORDS = 64,
	parameter int         REGIONS    = 16,
	parameter logic [15:0] LOCK_INIT = 16'h0000
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB register port
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	// Flash region memory port
	input  wire logic        mem_req,
	input  wire logic        mem_write,
	input  wire logic        mem_code,
	input  wire logic [19:0] mem_addr,
	input  wire logic [31:0] mem_wdata,
	output logic             mem_ready,
	output logic [31:0]      mem_rdata,
	// Controller interrupt and activity
	output logic             flash_irq,
	output logic             flash_busy
);
	import fpc_pkg::*;

	localparam int WORD_W = $clog2(PAGE_WORDS);
	localparam int PAGE_W = $clog2(PAGES);
	localparam int REG_W  = $clog2(REGIONS);
	localparam int ADDR_W = PAGE_W + WORD_W;
	localparam int RPG_W  = PAGE_W - REG_W;

	// Elaboration checks
	initial begin
		if (PAGE_W > FPC_PAGE_NUMBER_W || ADDR_W + 2 > 20 || REGIONS > 16 || REGIONS < 1)
			$error("fpc: geometry out of range");
		if ((1 << PAGE_W) != PAGES || (1 << WORD_W) != PAGE_WORDS || (1 << REG_W) != REGIONS)
			$error("fpc: sizes must be powers of two");
		if (WORD_W != 6)
			$error("fpc: page must be 256 bytes");
	end

	// Storage
	logic [31:0]        plane [0:PAGES*PAGE_WORDS-1];
	logic [31:0]        latch [0:PAGE_WORDS-1];
	logic [31:0]        buf_word [0:1];
	logic [ADDR_W-1:0]  buf_addr;
	logic               buf_valid;
	logic [REGIONS-1:0] region_lock_status;
	// Software-visible registers
	logic [31:0]        mode;
	logic               end_of_program_flag;
	logic               end_of_lock_flag;
	logic               lock_error_flag;
	logic               program_error_flag;
	logic [3:0]         rd_flags;
	// Sequencer state
	fpc_state_t         state;
	fpc_state_t         next_state;
	logic [PAGE_W-1:0]  page_number;
	logic [PAGE_W-1:0]  wipe_page;
	logic [WORD_W-1:0]  word_idx;
	logic [7:0]         step_tmr;
	logic               then_lock;
	logic               lock_val;
	// Memory port access counter and completion flag
	logic [2:0]         acc_cnt;
	logic               acc_done;
	// Mode register fields
	wire logic [1:0] flash_wait_states       = mode[FPC_FWS_LSB+:2];
	wire logic [7:0] microsecond_cycle_count = mode[FPC_MICROSECOND_CYCLE_COUNT_LSB+:8];
	wire logic       skip_erase_before_write = mode[FPC_SKIP_ERASE_BEFORE_WRITE_BIT];
	// APB decode
	wire logic apb_setup = psel && !penable;
	wire logic apb_acc   = psel && penable;
	wire logic hit_mode  = paddr == FPC_MODE_OFS;
	wire logic hit_cmd   = paddr == FPC_CMD_OFS;
	wire logic hit_stat  = paddr == FPC_STAT_OFS;
	wire logic hit_any   = hit_mode || hit_cmd || hit_stat;
	wire logic wr_mode   = apb_acc && pwrite && hit_mode;
	wire logic wr_cmd    = apb_acc && pwrite && hit_cmd;
	wire logic rd_stat   = apb_acc && !pwrite && hit_stat;
	assign pready  = 1'b1;
	assign pslverr = apb_acc && !hit_any;
	// Command decode
	wire logic [3:0] flash_command_code = pwdata[FPC_FLASH_COMMAND_CODE_LSB+:4];
	wire logic [PAGE_W-1:0] cmd_page    = pwdata[FPC_PAGE_NUMBER_LSB+:PAGE_W];
	wire logic key_ok  = pwdata[FPC_KEY_LSB+:8] == FPC_KEY;
	wire logic is_wp   = flash_command_code == FPC_CMD_WP;
	wire logic is_slb  = flash_command_code == FPC_CMD_SLB;
	wire logic is_wpl  = flash_command_code == FPC_CMD_WPL;
	wire logic is_clb  = flash_command_code == FPC_CMD_CLB;
	wire logic is_ea   = flash_command_code == FPC_CMD_EA;
	wire logic is_none = flash_command_code == FPC_CMD_NONE;
	wire logic code_ok = is_wp || is_slb || is_wpl || is_clb || is_ea;
	wire logic idle    = state == FPC_IDLE;
	wire logic cmd_go  = wr_cmd && idle && key_ok && code_ok;
	wire logic cmd_region_locked = region_lock_status[cmd_page[PAGE_W-1-:REG_W]];
	wire logic wp_blocked = (is_wp || is_wpl) && cmd_region_locked;
	wire logic ea_blocked = is_ea && (|region_lock_status);
	wire logic ev_lock_error_flag   = cmd_go && (wp_blocked || ea_blocked);
	wire logic ev_program_error_flag   = wr_cmd && idle && (!key_ok || (!code_ok && !is_none));
	// Sequencer step timing
	wire logic step_done  = step_tmr == 8'h00;
	wire logic last_word  = word_idx == WORD_W'(PAGE_WORDS - 1);
	wire logic last_page  = wipe_page == PAGE_W'(PAGES - 1);
	wire logic prog_end   = state == FPC_PROG && step_done && last_word;
	wire logic wipe_end   = state == FPC_WIPE && step_done && last_page;
	wire logic ev_eop     = prog_end || wipe_end;
	wire logic ev_eol     = state == FPC_LOCK && step_done;
	wire logic [ADDR_W-1:0] prog_addr = {page_number, word_idx};
	assign flash_busy = !idle;
	// Next sequencer state
	always_comb begin
		next_state = state;
		case (state)
			FPC_IDLE: begin
				if (cmd_go && !wp_blocked && !ea_blocked) begin
					if (is_wp || is_wpl)
						next_state = skip_erase_before_write ? FPC_PROG : FPC_ERASE;
					else if (is_ea)
						next_state = FPC_WIPE;
					else
						next_state = FPC_LOCK;
				end
			end
			FPC_ERASE: begin
				if (step_done)
					next_state = FPC_PROG;
			end
			FPC_PROG: begin
				if (prog_end)
					next_state = then_lock ? FPC_LOCK : FPC_IDLE;
			end
			FPC_LOCK: begin
				if (step_done)
					next_state = FPC_IDLE;
			end
			FPC_WIPE: begin
				if (wipe_end)
					next_state = FPC_IDLE;
			end
			default: next_state = FPC_IDLE;
		endcase
	end

	// Sequencer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state       <= FPC_IDLE;
			page_number <= '0;
			then_lock   <= 1'b0;
			lock_val    <= 1'b0;
		end else begin
			state <= next_state;
			if (cmd_go) begin
				page_number <= cmd_page;
				then_lock   <= is_wpl;
				lock_val    <= is_slb || is_wpl;
			end
		end
	end

	// Step timer and word/page counters
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_tmr  <= 8'h00;
			word_idx  <= '0;
			wipe_page <= '0;
		end else if (idle || step_done) begin
			step_tmr <= microsecond_cycle_count;
			if (idle) begin
				word_idx  <= '0;
				wipe_page <= '0;
			end else if (state == FPC_PROG) begin
				word_idx <= word_idx + 1'b1;
			end else if (state == FPC_WIPE) begin
				wipe_page <= wipe_page + 1'b1;
			end
		end else begin
			step_tmr <= step_tmr - 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			region_lock_status <= LOCK_INIT[REGIONS-1:0];
		else if (ev_eol)
			region_lock_status[page_number[PAGE_W-1-:REG_W]] <= lock_val;
	end

	// Memory plane erase and program
	always_ff @(posedge pclk) begin
		if (step_done && state == FPC_ERASE) begin
			for (int i = 0; i < PAGE_WORDS; i++)
				plane[{page_number, WORD_W'(i)}] <= '1;
		end
		if (step_done && state == FPC_WIPE) begin
			for (int i = 0; i < PAGE_WORDS; i++)
				plane[{wipe_page, WORD_W'(i)}] <= '1;
		end
		if (step_done && state == FPC_PROG)
			plane[prog_addr] <= plane[prog_addr] & latch[word_idx];
	end

	// Memory port decode
	// address wrap
	wire logic [ADDR_W-1:0] word_addr = mem_addr[ADDR_W+1:2];
	wire logic [ADDR_W-1:0] next_addr = buf_addr + 1'b1;
	wire logic same_word = mem_code && buf_valid && word_addr == buf_addr;
	wire logic seq_word  = mem_code && buf_valid && word_addr == next_addr;
	wire logic [2:0] fws3 = {1'b0, flash_wait_states};
	logic [2:0] need;
	// Cycles each access needs
	always_comb begin
		if (mem_write) begin
			need = flash_wait_states == FPC_FWS_MAX ? FPC_WR_CAP : fws3 + 3'h2;
		end else if (same_word) begin
			need = FPC_ONE_CYCLE;
		end else if (seq_word) begin
			need = flash_wait_states < 2'h2 ? FPC_ONE_CYCLE : fws3;
		end else begin
			need = fws3 + 3'h1;
		end
	end

	wire logic acc_live = mem_req && idle;
	wire logic acc_next = acc_cnt + 3'h1 == need;
	// Fire once per access; the buffers it loads would otherwise change need
	wire logic acc_fire = acc_live && acc_next && !acc_done;
	assign mem_ready = acc_live && acc_done;
	// Access counter and completion flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_cnt  <= 3'h0;
			acc_done <= 1'b0;
		end else begin
			acc_done <= acc_fire;
			acc_cnt  <= (!acc_live || mem_ready) ? 3'h0 : acc_cnt + 3'h1;
		end
	end

	// Read data and code buffers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_rdata <= 32'h0000_0000;
			buf_addr  <= '0;
			buf_valid <= 1'b0;
		end else if (acc_fire && !mem_write) begin
			mem_rdata <= same_word ? buf_word[0] : seq_word ? buf_word[1] : plane[word_addr];
			if (mem_code) begin
				buf_addr  <= word_addr;
				buf_valid <= 1'b1;
			end
		end else if (!idle) begin
			buf_valid <= 1'b0;
		end
	end
	always_ff @(posedge pclk) begin
		if (acc_fire && !mem_write && mem_code) begin
			buf_word[0] <= seq_word ? buf_word[1] : plane[word_addr];
			buf_word[1] <= plane[word_addr + 1'b1];
		end
	end
	always_ff @(posedge pclk) begin
		if (mem_ready && mem_write)
			latch[mem_addr[WORD_W+1:2]] <= mem_wdata;
	end

	// Mode register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mode <= FPC_MODE_RESET;
		else if (wr_mode)
			mode <= pwdata & 32'h00FF_038F;
	end

	// APB read data, captured at setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata   <= 32'h0000_0000;
			rd_flags <= 4'h0;
		end else if (apb_setup) begin
			rd_flags <= {program_error_flag, lock_error_flag, end_of_lock_flag, end_of_program_flag};
			if (hit_mode)
				prdata <= mode;
			else if (hit_stat)
				prdata <= {{(16-REGIONS){1'b0}}, region_lock_status, 12'h000,
					program_error_flag, lock_error_flag, end_of_lock_flag, end_of_program_flag};
			else
				prdata <= 32'h0000_0000;
		end
	end

	wire logic [3:0] flag_clr = rd_stat ? rd_flags : 4'h0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			end_of_program_flag <= 1'b0;
			end_of_lock_flag    <= 1'b0;
			lock_error_flag     <= 1'b0;
			program_error_flag  <= 1'b0;
		end else begin
			end_of_program_flag <= ev_eop || (end_of_program_flag && !flag_clr[0]);
			end_of_lock_flag    <= ev_eol || (end_of_lock_flag && !flag_clr[1]);
			lock_error_flag     <= ev_lock_error_flag || (lock_error_flag && !flag_clr[2]);
			program_error_flag  <= ev_program_error_flag || (program_error_flag && !flag_clr[3]);
		end
	end

	assign flash_irq = (end_of_program_flag && mode[FPC_EOP_BIT])
		|| (end_of_lock_flag && mode[FPC_EOL_BIT])
		|| (lock_error_flag && mode[FPC_LOCK_ERROR_FLAG_BIT])
		|| (program_error_flag && mode[FPC_PROGRAM_ERROR_FLAG_BIT]);

endmodule : fpc_flash_program_controller

// ==== verif/fpc_flash_program_controller_assertions.sv ====
// Checker of port timing and flag behaviour
`timescale 1ns/1ps
module fpc_flash_program_controller_assertions (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB side
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	// Memory side and status
	input wire logic        mem_req,
	input wire logic        mem_write,
	input wire logic        mem_code,
	input wire logic [19:0] mem_addr,
	input wire logic        mem_ready,
	input wire logic        flash_irq,
	input wire logic        flash_busy
);
	import fpc_pkg::*;
	logic [31:0] mode;
	logic [2:0]  cnt;
	logic [15:0] last_w;
	logic        have_last;
	// Access decode and expected latencies
	wire         acc   = psel && penable;
	wire [1:0]   ws    = mode[9:8];
	wire [15:0]  w_idx = mem_addr[17:2]; // Word within the wrapping region
	wire [2:0]   wr_n  = (ws == FPC_FWS_MAX) ? FPC_WR_CAP : {1'b0, ws} + 3'h2;
	wire [2:0]   seq_n = (ws <= 2'h1) ? FPC_ONE_CYCLE : {1'b0, ws};
	wire [2:0]   cd_n  = (w_idx == last_w) ? FPC_ONE_CYCLE : (w_idx == last_w + 16'h1) ? seq_n : {1'b0, ws} + 3'h1;
	// Mode shadow, cycle count, last code word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode      <= 32'h0000_0000;
			cnt       <= 3'h0;
			last_w    <= 16'h0000;
			have_last <= 1'b0;
		end else begin
			if (acc && pwrite && paddr == FPC_MODE_OFS) mode <= pwdata & 32'h00FF_038F;
			if (!mem_req || mem_ready) cnt <= 3'h0;
			else if (!flash_busy && cnt != 3'h7) cnt <= cnt + 3'h1;
			if (mem_ready && mem_code && !mem_write) last_w <= w_idx;
			have_last <= (have_last || (mem_ready && mem_code)) && !(mem_req && mem_write) && !flash_busy
				&& !(mem_ready && !mem_code);
		end
	end
	default clocking dcb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Port relations
	a_mode_readback: assert property (acc && !pwrite && paddr == FPC_MODE_OFS |-> prdata == mode)
		else $error("mode readback wrong");
	a_data_latency: assert property (mem_ready && !mem_write && !mem_code |-> cnt == {1'b0, ws} + 3'h1)
		else $error("data read latency wrong");
	a_write_latency: assert property (mem_ready && mem_req && mem_write |-> cnt == wr_n)
		else $error("latch write latency wrong");
	a_code_latency: assert property (mem_ready && mem_code && !mem_write && have_last |-> cnt == cd_n)
		else $error("code fetch latency wrong");
	a_ready_pulse: assert property (mem_ready |=> !mem_ready)
		else $error("ready longer than one cycle");
	a_busy_stall: assert property (flash_busy |-> !mem_ready)
		else $error("flash access during sequence");
	a_irq_masked: assert property (mode[3:0] == 4'h0 |-> !flash_irq)
		else $error("interrupt without enable");
	a_irq_clear: assert property (acc && !pwrite && paddr == FPC_STAT_OFS && !$past(flash_busy) |=> !flash_irq)
		else $error("interrupt kept after status read");
	a_key_guard: assert property (acc && pwrite && paddr == FPC_CMD_OFS && pwdata[31:24] != FPC_KEY
		&& !flash_busy |=> !flash_busy)
		else $error("sequence started without key");
endmodule : fpc_flash_program_controller_assertions
bind fpc_flash_program_controller fpc_flash_program_controller_assertions u_chk (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .mem_req, .mem_write, .mem_code, .mem_addr, .mem_ready,
	.flash_irq, .flash_busy);

// ==== verif/fpc_mem_master.sv ====
// Bus master model on the flash region port
`timescale 1ns/1ps
module fpc_mem_master (
	// Clock and completion
	input  wire logic   pclk,
	input  wire logic   mem_ready,
	// Request lines and hang flag
	output logic        mem_req,
	output logic        mem_write,
	output logic        mem_code,
	output logic [19:0] mem_addr,
	output logic [31:0] mem_wdata,
	output logic        hung
);
	initial begin
		mem_req   = 1'b0;
		mem_write = 1'b0;
		mem_code  = 1'b0;
		mem_addr  = 20'h0_0000;
		mem_wdata = 32'h0000_0000;
		hung      = 1'b0;
	end
	// One access held until ready, then lines scrambled
	task automatic acc(input logic w, input logic c, input logic [19:0] a, input logic [31:0] d, input int idle);
		int k;
		k = 0;
		repeat (idle) @(posedge pclk);
		@(posedge pclk);
		mem_req   <= 1'b1;
		mem_write <= w;
		mem_code  <= c;
		mem_addr  <= a;
		mem_wdata <= d;
		do begin
			@(posedge pclk);
			k++;
		end while (mem_ready !== 1'b1 && k < 2000);
		mem_req   <= 1'b0;
		mem_write <= ~w;
		mem_code  <= ~c;
		mem_addr  <= ~a;
		mem_wdata <= ~d;
		if (k >= 2000) hung <= 1'b1;
	endtask : acc
endmodule : fpc_mem_master

// ==== verif/flash_program_controller_tb.sv ====
// Self-checking bench of the flash program controller
`timescale 1ns/1ps
module flash_program_controller_tb;
	import fpc_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        mem_req, mem_write, mem_code, mem_ready, flash_irq, flash_busy, hung;
	logic [7:0]  paddr;
	logic [19:0] mem_addr;
	logic [31:0] pwdata, prdata, mem_wdata, mem_rdata, md, lk;
	logic [31:0] apb_q[$], mem_q[$], lat[64];
	logic [31:0] fl[int];
	logic [9:0]  pg;
	int          n_fail, tests_run, seed;
	wire         bad_addr = paddr != FPC_MODE_OFS && paddr != FPC_CMD_OFS && paddr != FPC_STAT_OFS;
	fpc_flash_program_controller dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
		.pslverr, .prdata, .mem_req, .mem_write, .mem_code, .mem_addr, .mem_wdata, .mem_ready, .mem_rdata,
		.flash_irq, .flash_busy);
	fpc_mem_master u_m (.pclk, .mem_ready, .mem_req, .mem_write, .mem_code, .mem_addr, .mem_wdata, .hung);
	// Clock
	always #5 pclk = ~pclk;
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : give_verdict
	task automatic cmp(input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %0t expected %h got %h", $time, e, g);
		end
	endtask : cmp
	function automatic logic [31:0] fv(int k);
		return fl.exists(k) ? fl[k] : 32'hFFFF_FFFF;
	endfunction : fv
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		psel    <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) begin
			n_fail++;
			give_verdict();
		end
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb_q.push_back(e);
		apb(1'b0, a, 32'h0000_0000);
	endtask : rd
	task automatic cmd(input logic [3:0] c, input logic [9:0] p, input logic [7:0] key);
		apb(1'b1, FPC_CMD_OFS, {key, 6'h00, p, 4'h0, c});
	endtask : cmd
	task automatic wait_idle;
		int k;
		k = 0;
		do begin
			@(negedge pclk);
			k++;
		end while (flash_busy === 1'b1 && k < 5000);
		if (k >= 5000) begin
			n_fail++;
			give_verdict();
		end
	endtask : wait_idle
	task automatic mr(input logic [19:0] a, input logic c);
		mem_q.push_back(fv(int'(a[17:2])));
		u_m.acc(1'b0, c, a, 32'h0000_0000, $urandom_range(0, 2));
	endtask : mr
	// Fill latch at random aliases, set mode, command, then check status
	task automatic prog(input logic [3:0] c, input logic nb, input logic [31:0] st);
		for (int i = 0; i < 64; i++) begin
			lat[i] = $urandom;
			u_m.acc(1'b1, 1'b0, {12'($urandom), 6'(i), 2'b00}, lat[i], 0);
		end
		md[7] = nb;
		apb(1'b1, FPC_MODE_OFS, md);
		cmd(c, pg, FPC_KEY);
		wait_idle();
		rd(FPC_STAT_OFS, st);
		for (int i = 0; i < 64 && !st[2]; i++) fl[int'({pg, 6'(i)})] = nb ? (fv(int'({pg, 6'(i)})) & lat[i]) : lat[i];
	endtask : prog
	// Result monitor
	always @(posedge pclk) begin
		if (psel && penable && !pwrite && apb_q.size() > 0) cmp(apb_q.pop_front(), prdata);
		if (psel && penable) cmp({31'h0, bad_addr}, {31'h0, pslverr});
		if (mem_ready && !mem_write && mem_q.size() > 0) cmp(mem_q.pop_front(), mem_rdata);
	end
	always @(posedge hung) begin
		n_fail++;
		give_verdict();
	end
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		n_fail = 0;
		tests_run = 0;
		seed = $urandom(52);
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(FPC_MODE_OFS, 32'h0000_0000);
		rd(FPC_STAT_OFS, 32'h0000_0000);
		rd(8'h6C, 32'h0000_0000);
		rd(FPC_CMD_OFS, 32'h0000_0000);
		cmd(FPC_CMD_WP, 10'h000, 8'hA5);
		rd(FPC_STAT_OFS, 32'h0000_0008);
		rd(FPC_STAT_OFS, 32'h0000_0000);
		cmd(4'h5, 10'h000, FPC_KEY);
		rd(FPC_STAT_OFS, 32'h0000_0008);
		cmd(FPC_CMD_NONE, 10'h000, FPC_KEY);
		rd(FPC_STAT_OFS, 32'h0000_0000);
		md = 32'h0000_0005;
		apb(1'b1, FPC_MODE_OFS, md);
		cmd(FPC_CMD_EA, 10'h000, FPC_KEY);
		wait_idle();
		fl.delete();
		cmp(32'h0000_0001, {31'h0, flash_irq});
		rd(FPC_STAT_OFS, 32'h0000_0001);
		@(negedge pclk);
		cmp(32'h0000_0000, {31'h0, flash_irq});
		md[3:0] = 4'hF;
		apb(1'b1, FPC_MODE_OFS, md);
		cmd(FPC_CMD_WP, 10'h000, 8'h00);
		@(negedge pclk);
		cmp(32'h0000_0001, {31'h0, flash_irq});
		rd(FPC_STAT_OFS, 32'h0000_0008);
		for (int w = 0; w < 4; w++) begin
			md[9:8] = 2'(w);
			pg = 10'($urandom);
			prog(FPC_CMD_WP, 1'b0, 32'h0000_0001);
			for (int j = 0; j < 12; j++) mr({2'($urandom), pg, 6'(j / 2), j[0], 1'b0}, 1'b1);
			repeat (3) mr(20'($urandom) & 20'hF_FFFC, 1'b0);
		end
		prog(FPC_CMD_WP, 1'b1, 32'h0000_0001);
		mr({2'h1, pg, 6'h05, 2'b00}, 1'b0);
		lk = 32'h0000_0001 << (16 + pg[9:6]);
		cmd(FPC_CMD_SLB, pg, FPC_KEY);
		wait_idle();
		rd(FPC_STAT_OFS, lk | 32'h0000_0002);
		prog(FPC_CMD_WP, 1'b0, lk | 32'h0000_0004);
		mr({2'h2, pg, 6'h05, 2'b00}, 1'b0);
		cmd(FPC_CMD_EA, 10'h000, FPC_KEY);
		wait_idle();
		rd(FPC_STAT_OFS, lk | 32'h0000_0004);
		// Longer steps so the next read overlaps the lock sequence
		md[23:16] = 8'h10;
		apb(1'b1, FPC_MODE_OFS, md);
		cmd(FPC_CMD_CLB, pg ^ 10'h03F, FPC_KEY);
		mr({2'h3, pg, 6'h05, 2'b00}, 1'b0);
		wait_idle();
		rd(FPC_STAT_OFS, 32'h0000_0002);
		pg = pg + 10'h040;
		lk = 32'h0000_0001 << (16 + pg[9:6]);
		prog(FPC_CMD_WPL, 1'b0, lk | 32'h0000_0003);
		cmd(FPC_CMD_CLB, pg, FPC_KEY);
		wait_idle();
		rd(FPC_STAT_OFS, 32'h0000_0002);
		@(posedge pclk);
		cmp(32'h0000_0000, 32'(apb_q.size() + mem_q.size()));
		give_verdict();
	end
endmodule : flash_program_controller_tb
